// ---- verilog/uhr_pkg.sv ----
// Constants shared by the host register and interrupt identification block
package uhr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER  = 3'h1;
  localparam logic [2:0] OFS_IIR  = 3'h2;
  localparam logic [2:0] OFS_LCR  = 3'h3;
  localparam logic [2:0] OFS_MCR  = 3'h4;
  localparam logic [2:0] OFS_LSR  = 3'h5;
  localparam logic [2:0] OFS_MSR  = 3'h6;
  localparam logic [2:0] OFS_SCR  = 3'h7;
  // ==========================================================================
  // Field positions
  localparam int IER_RX_DATA     = 0;
  localparam int IER_TX_EMPTY    = 1;
  localparam int IER_LINE_ERR    = 2;
  localparam int IER_HANDSHAKE   = 3;
  localparam int LCR_DIV_ACCESS  = 7;
  localparam int MCR_IRQ_GATE    = 3;
  localparam int FCR_ENABLE      = 0;
  localparam int FCR_RX_RESET    = 1;
  localparam int FCR_TX_RESET    = 2;
  localparam int FCR_DMA_MODE    = 3;
  localparam int FCR_DEEP        = 5;
  localparam int FCR_TRIG_LO     = 6;
  localparam int IIR_DEEP        = 5;
  localparam int ERR_PARITY      = 0;
  localparam int ERR_FRAME       = 1;
  localparam int ERR_BREAK       = 2;
  // ==========================================================================
  // Masks and identification codes (bits 3:0 of the identification byte)
  localparam logic [7:0] IER_MASK     = 8'h0F;
  localparam logic [7:0] MCR_MASK     = 8'h3F;
  localparam logic [3:0] ID_NONE      = 4'h1;
  localparam logic [3:0] ID_LINE_ERR  = 4'h6;
  localparam logic [3:0] ID_RX_DATA   = 4'h4;
  localparam logic [3:0] ID_TIMEOUT   = 4'hC;
  localparam logic [3:0] ID_TX_EMPTY  = 4'h2;
  localparam logic [3:0] ID_HANDSHAKE = 4'h0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
  // ==========================================================================
  // Receive trigger levels, standard and deep queues, per threshold code
  localparam logic [6:0] TRIG_STD [4] = '{7'h01, 7'h04, 7'h08, 7'h0E};
  localparam logic [6:0] TRIG_DEEP[4] = '{7'h01, 7'h10, 7'h20, 7'h38};
  // Idle character times before a receive timeout
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
endpackage

// ---- verilog/uhr_regs.sv ----
// Host register file, character queues and interrupt identification
// Function
// RL1: Reset selects single-buffer character mode
// RL2: Queue mode gives 16 or 64-byte queues
// RL3: Requests follow enables, gated by gate output
// RL4: Offset zero reads receive, writes transmit
// RL5: Offset two: read identify, write queue control
// RL6: Divisor access maps offsets zero, one
// RL7: Enable bit 3 handshake change interrupt
// RL8: Enable bit 2 line error interrupt
// RL9: Enable bit 1 transmit empty interrupt
// RL10: Enable bit 0 receive data, timeout
// RL11: Identify read freezes reported highest source
// RL12: Identify bits 7,6 show queue mode
// RL13: Identify bit 5 shows deep queues
// RL14: Identify bit 0 low means pending
// RL15: Code bit 3 zero outside queue mode; a pending timeout keeps code 110 for the first cycle after queue mode is left
// RL16: Line error first, code 011, status clears
// RL17: Receive data second, code 010, level based
// RL18: Timeout second, code 110, four characters
// RL19: Transmit empty third, code 001, clears
// RL20: Handshake change fourth, code 000, status clears
// RL21: Queue control is write-only
// RL22: Format bit 7 selects divisor access
// RL23: Handshake bit 3 drives gate low
// RL24: Queue control ignored unless enable set
// RL25: Enable bits 7..4 read zero
// RL26: Host interrupt is pending and gate, registered
`timescale 1ns/1ns
`default_nettype none
module uhr_regs #(
  parameter int QUEUE_DEPTH = 16,
  parameter int DEEP_DEPTH  = 64,
  parameter bit HAS_DEEP    = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_push_data,
  input  wire logic [2:0]  rx_push_err,
  input  wire logic        char_time_tick,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        tx_shift_empty,
  input  wire logic [3:0]  handshake_in,
  output logic      [15:0] baud_divisor,
  output logic      [7:0]  frame_format,
  output logic      [7:0]  handshake_ctl,
  output logic             dma_mode,
  output logic             queue_mode_flag,
  output logic             host_irq_gate_output_n,
  output logic             host_irq
);
  localparam int MEM_DEPTH = HAS_DEEP ? DEEP_DEPTH : QUEUE_DEPTH;
  localparam int PW        = $clog2(MEM_DEPTH);
  localparam int CW        = $clog2(MEM_DEPTH + 1);

  // ==========================================================================
  // Register state
  logic [7:0]  ier_q;
  logic [7:0]  lcr_q;
  logic [7:0]  mcr_q;
  logic [7:0]  scr_q;
  logic [15:0] div_q;
  logic        fifo_en_q;
  logic        deep_en_q;
  logic        dma_q;
  logic [1:0]  trig_sel_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic divisor_access_select;
  logic wr_data;
  logic wr_fcr;
  logic rd_data;
  logic rd_iir;
  logic rd_lsr;
  logic rd_msr;
  assign divisor_access_select    = lcr_q[uhr_pkg::LCR_DIV_ACCESS]; // RL22
  assign wr_data = io_wr && io_addr == uhr_pkg::OFS_DATA && !divisor_access_select; // RL4
  assign wr_fcr  = io_wr && io_addr == uhr_pkg::OFS_IIR; // RL5
  assign rd_data = io_rd && io_addr == uhr_pkg::OFS_DATA && !divisor_access_select; // RL4
  assign rd_iir  = io_rd && io_addr == uhr_pkg::OFS_IIR; // RL5
  assign rd_lsr  = io_rd && io_addr == uhr_pkg::OFS_LSR;
  assign rd_msr  = io_rd && io_addr == uhr_pkg::OFS_MSR;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ier_q <= uhr_pkg::RST_BYTE;
      lcr_q <= uhr_pkg::RST_BYTE;
      mcr_q <= uhr_pkg::RST_BYTE;
      scr_q <= uhr_pkg::RST_BYTE;
      div_q <= uhr_pkg::RST_DIVISOR;
    end else if (io_wr) begin
      unique case (io_addr)
        uhr_pkg::OFS_DATA: begin
          if (divisor_access_select) begin
            div_q[7:0] <= io_wdata; // RL6
          end
        end
        uhr_pkg::OFS_IER: begin
          if (divisor_access_select) begin
            div_q[15:8] <= io_wdata; // RL6
          end else begin
            ier_q <= io_wdata & uhr_pkg::IER_MASK; // RL25
          end
        end
        uhr_pkg::OFS_LCR: lcr_q <= io_wdata;
        uhr_pkg::OFS_MCR: mcr_q <= io_wdata & uhr_pkg::MCR_MASK;
        uhr_pkg::OFS_SCR: scr_q <= io_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Queue control, write-only
  logic rx_clr;
  logic tx_clr;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fifo_en_q  <= 1'b0; // RL1
      deep_en_q  <= 1'b0;
      dma_q      <= 1'b0;
      trig_sel_q <= 2'h0;
    end else if (wr_fcr) begin
      fifo_en_q <= io_wdata[uhr_pkg::FCR_ENABLE]; // RL21
      if (io_wdata[uhr_pkg::FCR_ENABLE]) begin // RL24
        dma_q      <= io_wdata[uhr_pkg::FCR_DMA_MODE];
        trig_sel_q <= io_wdata[uhr_pkg::FCR_TRIG_LO +: 2];
        if (divisor_access_select) begin
          deep_en_q <= HAS_DEEP && io_wdata[uhr_pkg::FCR_DEEP]; // RL2
        end
      end
    end
  end

  // Leaving or entering queue mode, or a clear of enable, empties both queues
  assign rx_clr = wr_fcr && (!io_wdata[uhr_pkg::FCR_ENABLE] || io_wdata[uhr_pkg::FCR_RX_RESET] ||
                  !fifo_en_q); // RL24
  assign tx_clr = wr_fcr && (!io_wdata[uhr_pkg::FCR_ENABLE] || io_wdata[uhr_pkg::FCR_TX_RESET] ||
                  !fifo_en_q); // RL24
  logic [CW-1:0] cap;
  logic [6:0]    trig;
  always_comb begin
    if (!fifo_en_q) begin
      cap = CW'(1); // RL1
    end else if (deep_en_q) begin
      cap = CW'(DEEP_DEPTH); // RL2
    end else begin
      cap = CW'(QUEUE_DEPTH); // RL2
    end
    trig = deep_en_q ? uhr_pkg::TRIG_DEEP[trig_sel_q] : uhr_pkg::TRIG_STD[trig_sel_q];
  end

  // ==========================================================================
  // Receive queue with per-character error bits
  logic [10:0]   rx_mem [MEM_DEPTH];
  logic [PW-1:0] rx_wp_q;
  logic [PW-1:0] rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic          rx_empty;
  logic          rx_pop;
  logic          rx_acc;
  logic          rx_ovr;
  assign rx_empty = rx_cnt_q == '0;
  assign rx_pop   = rd_data && !rx_empty; // RL4
  assign rx_acc   = rx_push && (rx_cnt_q < cap || rx_pop);
  assign rx_ovr   = rx_push && !rx_acc;
  always_ff @(posedge ref_clk) begin
    if (rx_acc) begin
      rx_mem[rx_wp_q] <= {rx_push_err, rx_push_data};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || rx_clr) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      rx_wp_q  <= rx_wp_q + PW'(rx_acc);
      rx_rp_q  <= rx_rp_q + PW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + CW'(rx_acc) - CW'(rx_pop);
    end
  end

  // ==========================================================================
  // Transmit queue
  logic [7:0]    tx_mem [MEM_DEPTH];
  logic [PW-1:0] tx_wp_q;
  logic [PW-1:0] tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  logic          tx_empty;
  logic          tx_pop;
  logic          tx_acc;
  assign tx_empty = tx_cnt_q == '0;
  assign tx_pop   = tx_ready && !tx_empty;
  assign tx_acc   = wr_data && tx_cnt_q < cap; // RL4
  assign tx_valid = !tx_empty;
  assign tx_data  = tx_mem[tx_rp_q];
  always_ff @(posedge ref_clk) begin
    if (tx_acc) begin
      tx_mem[tx_wp_q] <= io_wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || tx_clr) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      tx_wp_q  <= tx_wp_q + PW'(tx_acc);
      tx_rp_q  <= tx_rp_q + PW'(tx_pop);
      tx_cnt_q <= tx_cnt_q + CW'(tx_acc) - CW'(tx_pop);
    end
  end

  // ==========================================================================
  // Line status: errors latch when their character reaches the head
  logic       head_seen_q;
  logic       oe_q;
  logic [2:0] err_q;
  logic [2:0] head_err;
  logic       head_new;
  assign head_err = rx_mem[rx_rp_q][10:8];
  assign head_new = !rx_empty && !head_seen_q;
  always_ff @(posedge ref_clk) begin
    if (rst || rx_clr || rx_pop) begin
      head_seen_q <= 1'b0;
    end else if (head_new) begin
      head_seen_q <= 1'b1;
    end
  end
  // Set wins over the clear by a status read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oe_q  <= 1'b0;
      err_q <= 3'h0;
    end else begin
      oe_q  <= rx_ovr || (oe_q && !rd_lsr); // RL16
      err_q <= (head_new ? head_err : 3'h0) | (rd_lsr ? 3'h0 : err_q); // RL16
    end
  end
  logic       line_err;
  logic [7:0] lsr;
  assign line_err = oe_q || (|err_q);
  always_comb begin
    lsr    = 8'h00;
    lsr[0] = !rx_empty;
    lsr[1] = oe_q;
    lsr[2] = err_q[uhr_pkg::ERR_PARITY];
    lsr[3] = err_q[uhr_pkg::ERR_FRAME];
    lsr[4] = err_q[uhr_pkg::ERR_BREAK];
    lsr[5] = tx_empty;
    lsr[6] = tx_empty && tx_shift_empty;
    lsr[7] = fifo_en_q && (|err_q);
  end

  // ==========================================================================
  // Handshake input changes
  logic [3:0] hs_prev_q;
  logic [3:0] hs_delta_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_prev_q  <= 4'h0;
      hs_delta_q <= 4'h0;
    end else begin
      hs_prev_q  <= handshake_in;
      hs_delta_q <= (handshake_in ^ hs_prev_q) | (rd_msr ? 4'h0 : hs_delta_q); // RL20
    end
  end

  // ==========================================================================
  // Receive timeout after idle character times
  logic [2:0] to_cnt_q;
  logic       to_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !fifo_en_q || rx_empty || rx_acc || rx_pop) begin
      to_cnt_q <= 3'h0;
    end else if (char_time_tick && to_cnt_q != uhr_pkg::TIMEOUT_CHARS) begin
      to_cnt_q <= to_cnt_q + 3'h1; // RL18
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !fifo_en_q || rx_empty || rx_pop) begin
      to_q <= 1'b0; // RL18
    end else if (char_time_tick && !rx_acc && to_cnt_q == uhr_pkg::TIMEOUT_CHARS - 3'h1) begin
      to_q <= 1'b1; // RL18
    end
  end

  // ==========================================================================
  // Transmit empty event
  logic tx_empty_prev_q;
  logic thre_q;
  logic thre_set;
  logic thre_clr;
  logic [3:0] id_code;
  assign thre_set = (tx_empty && !tx_empty_prev_q) ||
                    (io_wr && io_addr == uhr_pkg::OFS_IER && !divisor_access_select &&
                     io_wdata[uhr_pkg::IER_TX_EMPTY] && !ier_q[uhr_pkg::IER_TX_EMPTY] && tx_empty);
  assign thre_clr = wr_data || (rd_iir && id_code == uhr_pkg::ID_TX_EMPTY); // RL19
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_empty_prev_q <= 1'b1;
      thre_q          <= 1'b0;
    end else begin
      tx_empty_prev_q <= tx_empty;
      thre_q          <= thre_set || (thre_q && !thre_clr); // RL19
    end
  end

  // ==========================================================================
  // Prioritised identification
  logic ls_pend;
  logic rx_pend;
  logic to_pend;
  logic tx_pend;
  logic hs_pend;
  logic any_pend;
  assign ls_pend  = ier_q[uhr_pkg::IER_LINE_ERR] && line_err; // RL8
  assign rx_pend  = ier_q[uhr_pkg::IER_RX_DATA] &&
                    (fifo_en_q ? rx_cnt_q >= CW'(trig) : !rx_empty); // RL10 RL17
  assign to_pend  = ier_q[uhr_pkg::IER_RX_DATA] && to_q; // RL10
  assign tx_pend  = ier_q[uhr_pkg::IER_TX_EMPTY] && thre_q; // RL9
  assign hs_pend  = ier_q[uhr_pkg::IER_HANDSHAKE] && (|hs_delta_q); // RL7
  assign any_pend = ls_pend || rx_pend || to_pend || tx_pend || hs_pend; // RL3
  always_comb begin
    if (ls_pend) begin
      id_code = uhr_pkg::ID_LINE_ERR; // RL16
    end else if (rx_pend) begin
      id_code = uhr_pkg::ID_RX_DATA; // RL17
    end else if (to_pend) begin
      id_code = uhr_pkg::ID_TIMEOUT; // RL18 RL15
    end else if (tx_pend) begin
      id_code = uhr_pkg::ID_TX_EMPTY; // RL19
    end else if (hs_pend) begin
      id_code = uhr_pkg::ID_HANDSHAKE; // RL20
    end else begin
      id_code = uhr_pkg::ID_NONE; // RL14
    end
  end
  logic [7:0] iir;
  always_comb begin
    iir      = {4'h0, id_code};
    iir[7:6] = {2{fifo_en_q}}; // RL12
    iir[uhr_pkg::IIR_DEEP] = fifo_en_q && deep_en_q; // RL13
  end

  // ==========================================================================
  // Read data; the identification byte is taken in the read cycle itself
  logic [7:0] rdata_d;
  always_comb begin
    unique case (io_addr)
      uhr_pkg::OFS_DATA: rdata_d = divisor_access_select ? div_q[7:0] : rx_mem[rx_rp_q][7:0]; // RL4 RL6
      uhr_pkg::OFS_IER:  rdata_d = divisor_access_select ? div_q[15:8] : ier_q; // RL6 RL25
      uhr_pkg::OFS_IIR:  rdata_d = iir; // RL11
      uhr_pkg::OFS_LCR:  rdata_d = lcr_q;
      uhr_pkg::OFS_MCR:  rdata_d = mcr_q;
      uhr_pkg::OFS_LSR:  rdata_d = lsr;
      uhr_pkg::OFS_MSR:  rdata_d = {hs_prev_q, hs_delta_q};
      uhr_pkg::OFS_SCR:  rdata_d = scr_q;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= uhr_pkg::RST_BYTE;
    end else if (io_rd) begin
      rdata_q <= rdata_d; // RL11
    end
  end

  // ==========================================================================
  // Host interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_pend && mcr_q[uhr_pkg::MCR_IRQ_GATE]; // RL26 RL3
    end
  end
  assign io_rdata               = rdata_q;
  assign baud_divisor           = div_q;
  assign frame_format           = lcr_q;
  assign handshake_ctl          = mcr_q;
  assign dma_mode               = dma_q;
  assign queue_mode_flag        = fifo_en_q;
  assign host_irq_gate_output_n = !mcr_q[uhr_pkg::MCR_IRQ_GATE]; // RL23
  assign host_irq               = irq_q;
endmodule
`default_nettype wire

// ---- dv/uhr_regs_sva.sv ----
// Checker for the host register block port relations
`timescale 1ns/1ns
`default_nettype none
module uhr_regs_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [2:0]  io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        tx_valid,
  input wire logic [15:0] baud_divisor,
  input wire logic [7:0]  frame_format,
  input wire logic [7:0]  handshake_ctl,
  input wire logic        queue_mode_flag,
  input wire logic        host_irq_gate_output_n,
  input wire logic        host_irq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Access sequences
  sequence id_rd;
    io_rd && io_addr == 3'h2;
  endsequence
  sequence ctl_wr;
    io_wr && io_addr == 3'h2;
  endsequence
  // ==========================================================================
  // Assertions
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    io_rdata == 8'h00 && !host_irq && !queue_mode_flag && !tx_valid && host_irq_gate_output_n)
    else $error("state not cleared by reset");
  gate_level_a: assert property (host_irq_gate_output_n == !handshake_ctl[3])
    else $error("gate output does not follow control bit");
  irq_gated_a: assert property (!handshake_ctl[3] |=> !host_irq)
    else $error("host interrupt raised while gate inactive");
  id_mode_a: assert property (id_rd |=> io_rdata[7:6] == {2{$past(queue_mode_flag)}} && !io_rdata[4])
    else $error("identify mode bits wrong");
  id_plain_a: assert property (id_rd ##0 !queue_mode_flag |=> !io_rdata[5] && !io_rdata[3])
    else $error("queue-only identify bits set outside queue mode");
  id_idle_a: assert property (id_rd |=> io_rdata[0] == (io_rdata[3:0] == 4'h1))
    else $error("pending bit disagrees with code");
  irq_match_a: assert property (id_rd |=> host_irq == ($past(handshake_ctl[3]) && !io_rdata[0]))
    else $error("host interrupt disagrees with identify");
  div_load_a: assert property (io_wr && frame_format[7] && io_addr == 3'h0 |=>
    baud_divisor[7:0] == $past(io_wdata))
    else $error("divisor low byte not loaded");
  div_hold_a: assert property (io_wr && !frame_format[7] && io_addr <= 3'h1 |=> $stable(baud_divisor))
    else $error("divisor changed without divisor access");
  ctl_off_a: assert property (ctl_wr ##0 !io_wdata[0] |=> !queue_mode_flag)
    else $error("queue mode kept after disable");
  ctl_on_a: assert property (ctl_wr ##0 io_wdata[0] |=> queue_mode_flag)
    else $error("queue mode not engaged");
endmodule
bind uhr_regs uhr_regs_sva chk_u (.ref_clk, .rst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
  .tx_valid, .baud_divisor, .frame_format, .handshake_ctl, .queue_mode_flag, .host_irq_gate_output_n,
  .host_irq);
`default_nettype wire

// ---- dv/uhr_line_model.sv ----
// Line-side engine model: transmit drain and character-time ticks
`timescale 1ns/1ns
`default_nettype none
module uhr_line_model #(
  parameter int TICK_DIV = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       stall,
  output logic            tx_ready,
  output logic            char_time_tick,
  output logic      [7:0] last_tx
);
  logic [7:0] div_q;
  assign tx_ready = !stall;
  assign char_time_tick = (div_q == 8'(TICK_DIV - 1));
  // ==========================================================================
  // Free-running character times
  always_ff @(posedge ref_clk) begin
    if (rst || char_time_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  // ==========================================================================
  // Capture each character the shift engine takes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_tx <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      last_tx <= tx_data;
    end
  end
endmodule
`default_nettype wire

// ---- dv/uhr_regs_tb.sv ----
// Self-checking bench for the host register block
`timescale 1ns/1ns
`default_nettype none
module uhr_regs_tb;
  logic        ref_clk;
  logic        rst;
  logic [2:0]  io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        rx_push;
  logic [7:0]  rx_push_data;
  logic [2:0]  rx_push_err;
  logic        char_time_tick;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic [3:0]  handshake_in;
  logic [15:0] baud_divisor;
  logic [7:0]  frame_format;
  logic        dma_mode;
  logic        queue_mode_flag;
  logic        host_irq_gate_output_n;
  logic        host_irq;
  logic        stall;
  logic [7:0]  last_tx;
  logic [7:0]  v;
  int          bad_count;
  int          total_checks;
  uhr_regs dut_u (.ref_clk, .rst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .rx_push,
    .rx_push_data, .rx_push_err, .char_time_tick, .tx_valid, .tx_data, .tx_ready, .tx_shift_empty(1'b1),
    .handshake_in, .baud_divisor, .frame_format, .handshake_ctl(), .dma_mode, .queue_mode_flag,
    .host_irq_gate_output_n, .host_irq);
  uhr_line_model line_u (.ref_clk, .rst, .tx_valid, .tx_data, .stall, .tx_ready, .char_time_tick, .last_tx);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cyc(1);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    cyc(1);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic push(input logic [7:0] d, input logic [2:0] e);
    cyc(1);
    rx_push = 1'b1;
    rx_push_data = d;
    rx_push_err = e;
    cyc(1);
    rx_push = 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    stop_test;
  end
  // ==========================================================================
  // Tests
  initial begin
    {rst, io_rd, io_wr, rx_push, stall} = 5'h10;
    {io_addr, io_wdata, rx_push_data, rx_push_err, handshake_in} = '0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rdc(3'h2, 8'h01);
    rdc(3'h1, 8'h00);
    chk(host_irq_gate_output_n, 1'b1);
    wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F);
    wr(3'h7, 8'hA6);
    rdc(3'h7, 8'hA6);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(baud_divisor, 16'h1234);
    rdc(3'h0, 8'h34);
    chk(tx_valid, 1'b0);
    wr(3'h3, 8'h03);
    chk(frame_format, 8'h03);
    rdc(3'h1, 8'h0F);
    $display("test registers done");
    wr(3'h1, 8'h00);
    wr(3'h1, 8'h02);
    cyc(2);
    chk(host_irq, 1'b0);
    wr(3'h4, 8'h08);
    cyc(2);
    chk(host_irq, 1'b1);
    chk(host_irq_gate_output_n, 1'b0);
    rdc(3'h2, 8'h02);
    rdc(3'h2, 8'h01);
    stall = 1'b1;
    wr(3'h1, 8'h00);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h5A);
    rdc(3'h2, 8'h01);
    stall = 1'b0;
    cyc(2);
    chk(last_tx, 8'h5A);
    rdc(3'h2, 8'h02);
    $display("test transmit done");
    wr(3'h1, 8'h01);
    push(8'hA5, 3'h0);
    cyc(2);
    rdc(3'h2, 8'h04);
    rdc(3'h0, 8'hA5);
    rdc(3'h2, 8'h01);
    push(8'h3C, 3'h1);
    cyc(2);
    rdc(3'h2, 8'h04);
    wr(3'h1, 8'h05);
    rdc(3'h2, 8'h06);
    rd(3'h5, v);
    chk(v[2], 1'b1);
    rdc(3'h2, 8'h04);
    rdc(3'h0, 8'h3C);
    $display("test receive done");
    wr(3'h1, 8'h08);
    handshake_in = 4'h8;
    cyc(3);
    rdc(3'h2, 8'h00);
    chk(host_irq, 1'b1);
    rdc(3'h6, 8'h88);
    rdc(3'h2, 8'h01);
    $display("test handshake done");
    wr(3'h1, 8'h01);
    wr(3'h2, 8'hC9);
    chk(dma_mode, 1'b1);
    for (int i = 1; i <= 3; i++) push(8'(i), 3'h0);
    cyc(60);
    rdc(3'h2, 8'hCC);
    rdc(3'h0, 8'h01);
    rdc(3'h2, 8'hC1);
    for (int i = 4; i <= 16; i++) push(8'(i), 3'h0);
    rdc(3'h2, 8'hC4);
    push(8'h11, 3'h0);
    rd(3'h5, v);
    chk(v[1], 1'b0);
    push(8'h12, 3'h0);
    rd(3'h5, v);
    chk(v[1], 1'b1);
    wr(3'h2, 8'h06);
    chk(queue_mode_flag, 1'b0);
    chk(dma_mode, 1'b1);
    rdc(3'h2, 8'h01);
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h21);
    wr(3'h3, 8'h03);
    rdc(3'h2, 8'hE1);
    chk(dma_mode, 1'b0);
    $display("test queues done");
    stop_test;
  end
endmodule
`default_nettype wire
